// [core/fllrs_pkg.sv]
package fllrs_pkg;

  // ---------------------------------------------------------------
  // register indexes (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_RATE_STATUS = 12'h212;
  localparam logic [11:0] IDX_LOOP_CTRL   = 12'h220;
  localparam logic [11:0] IDX_LOOP_DIV    = 12'h221;
  localparam logic [11:0] IDX_FRAC_NUM    = 12'h222;
  localparam logic [11:0] IDX_INT_MULT    = 12'h223;
  localparam logic [11:0] IDX_REF_DIV     = 12'h224;
  localparam logic [11:0] IDX_FRAC_DEN    = 12'h226;
  localparam logic [11:0] IDX_FRAC_MODE   = 12'h227;
  localparam logic [11:0] IDX_IRQ_STATUS  = 12'h230;
  localparam logic [11:0] IDX_IRQ_ENABLE  = 12'h231;
  localparam logic [11:0] IDX_IRQ_CLEAR   = 12'h232;
  localparam logic [11:0] IDX_EFF_MULT    = 12'h233;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int unsigned LOOP_EN_BIT  = 0;
  localparam int unsigned OSC_EN_BIT   = 1;
  localparam int unsigned OUTDIV_LSB   = 8;
  localparam int unsigned OUTDIV_W     = 6;
  localparam int unsigned RATIO_LSB    = 0;
  localparam int unsigned RATIO_W      = 3;
  localparam int unsigned FRAC_W       = 16;
  localparam int unsigned INT_LSB      = 5;
  localparam int unsigned INT_W        = 10;
  localparam int unsigned REFDIV_LSB   = 3;
  localparam int unsigned REFDIV_W     = 2;
  localparam int unsigned FMODE_BIT    = 0;
  localparam int unsigned MULT_W       = 15;

  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [1:0]  RST_LOOP_CTRL = 2'h0;
  localparam logic [5:0]  RST_OUTDIV    = 6'h00;
  localparam logic [2:0]  RST_RATIO     = 3'h0;
  localparam logic [15:0] RST_FRAC      = 16'h0000;
  localparam logic [9:0]  RST_INT       = 10'h000;
  localparam logic [1:0]  RST_REFDIV    = 2'h0;
  localparam logic [15:0] FMODE_RSVD    = 16'h0006;
  localparam logic [5:0]  OUTDIV_MIN    = 6'h03;

  // ---------------------------------------------------------------
  // rate error codes and rate field limits
  // ---------------------------------------------------------------
  localparam logic [3:0] RERR_NONE      = 4'h0;
  localparam logic [3:0] RERR_SR        = 4'h1;
  localparam logic [3:0] RERR_DIV       = 4'h2;
  localparam logic [3:0] RERR_BOTH_DIV  = 4'h3;
  localparam logic [3:0] RERR_DIV_SR    = 4'h4;
  localparam logic [3:0] RERR_96K_EN    = 4'h5;
  localparam logic [3:0] RERR_SYSTEM_CLOCK    = 4'h6;
  localparam logic [3:0] RERR_ASYNC_MIX = 4'h7;
  localparam logic [3:0] RERR_SHR_SR    = 4'h8;
  localparam logic [3:0] RERR_SHR_MIX   = 4'h9;
  localparam logic [3:0] SR_MAX         = 4'ha;
  localparam logic [3:0] SR_88K2        = 4'h9;
  localparam logic [3:0] CLKR_MAX       = 4'h9;
  localparam logic [3:0] CLKR_1408      = 4'h8;
  localparam logic [4:0] BDIV_MAX       = 5'h13;

  // ---------------------------------------------------------------
  // interrupt event bits
  // ---------------------------------------------------------------
  localparam int unsigned EV_W          = 4;
  localparam int unsigned EV_RATE_ERR   = 0;
  localparam int unsigned EV_OUTDIV_BAD = 1;
  localparam int unsigned EV_FRAC_MODE  = 2;
  localparam int unsigned EV_LOOP_ON    = 3;

endpackage

// [core/fllrs_rate_if.sv]
`timescale 1ns/100ps
interface fllrs_rate_if;
  logic [1:0][3:0] sample_rate;
  logic [1:0][3:0] clk_ratio;
  logic [1:0][4:0] bclk_div;
  logic [1:0]      adc_en;
  logic [1:0]      dac_en;
  logic [1:0]      adc_div_set;
  logic [1:0]      dac_div_set;
  logic            same_source;
  logic            system_clock_aif;
  logic [3:0]      err_code;

  modport chk  (input  sample_rate, clk_ratio, bclk_div, adc_en, dac_en,
                       adc_div_set, dac_div_set, same_source, system_clock_aif,
                output err_code);
  modport ctrl (output sample_rate, clk_ratio, bclk_div, adc_en, dac_en,
                       adc_div_set, dac_div_set, same_source, system_clock_aif,
                input  err_code);
endinterface

// [core/fllrs_rate_check.sv]
`timescale 1ns/100ps
module fllrs_rate_check
  import fllrs_pkg::*;
(
  fllrs_rate_if.chk rif
);

  // ---------------------------------------------------------------
  // per-interface checks
  // ---------------------------------------------------------------
  logic [1:0] bad_sr;
  logic [1:0] bad_div;
  logic [1:0] both_div;
  logic [1:0] div_sr;
  logic [1:0] en_96k;
  logic [1:0] bad_clk;
  logic [1:0] mixed;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_aif
      assign bad_sr[i]   = rif.sample_rate[i] > SR_MAX;
      assign bad_div[i]  = rif.bclk_div[i] > BDIV_MAX;
      assign both_div[i] = rif.adc_div_set[i] & rif.dac_div_set[i];
      // the 1408 ratio only suits the 44.1kHz family
      assign div_sr[i]   = (rif.clk_ratio[i] == CLKR_1408) &&
                           !(rif.sample_rate[i] inside {4'h1, 4'h4, 4'h7,
                                                        4'h9});
      // high rates are playback only
      assign en_96k[i]   = (rif.sample_rate[i] >= SR_88K2) &
                           rif.adc_en[i];
      assign bad_clk[i]  = (rif.clk_ratio[i] == 4'h0) ||
                           (rif.clk_ratio[i] > CLKR_MAX);
      assign mixed[i]    = rif.adc_en[i] & rif.dac_en[i];
    end
  endgenerate

  wire async_mix = !rif.same_source && mixed[rif.system_clock_aif];
  wire shr_sr    = rif.same_source &&
                   (rif.sample_rate[0] != rif.sample_rate[1]);
  wire shr_mix   = rif.same_source && (mixed != 2'b00);

  // lowest code wins when several faults stand at once
  assign rif.err_code = (|bad_sr)   ? RERR_SR        : // RL1
                        (|bad_div)  ? RERR_DIV       : // RL2
                        (|both_div) ? RERR_BOTH_DIV  : // RL2
                        (|div_sr)   ? RERR_DIV_SR    : // RL2
                        (|en_96k)   ? RERR_96K_EN    : // RL2
                        (|bad_clk)  ? RERR_SYSTEM_CLOCK    : // RL3
                        async_mix   ? RERR_ASYNC_MIX : // RL3
                        shr_sr      ? RERR_SHR_SR    : // RL3
                        shr_mix     ? RERR_SHR_MIX   : // RL3
                                      RERR_NONE;     // RL1

endmodule

// [core/fllrs_ctrl.sv]
// How it works
// RL1 - a 4-bit read-only rate error field reads 0000 for no error and 0001 for a bad sample rate.
// RL2 - codes 0010 to 0101 flag a bad divide, both divides set, a bad divide/rate pair and bad 96k enables.
// RL3 - codes 0110 to 1001 flag a bad system clock ratio, async mixed rates and shared-source clashes.
// RL4 - bit 1 of the loop control register starts the oscillator for free-running use.
// RL5 - software sets loop enable, bit 0, last, after every other loop field is written.
// RL6 - the 6-bit output divider in bits 13:8 divides the VCO by code plus one, codes below 3 reserved.
// RL7 - the VCO ratio in bits 2:0 selects 1, 2, 4, 8, or 16 for any code with the top bit set.
// RL8 - a 16-bit unsigned field is the fractional numerator of the reference multiply.
// RL9 - a 10-bit unsigned field in bits 14:5 is the integer reference multiplier.
// RL10 - a separate 16-bit field is the fractional denominator.
// RL11 - software sets fractional mode whenever the numerator is above zero.
// RL12 - software picks a reference divide of 1, 2, 4 or 8 to keep the divided reference at or below 13.5MHz.
// RL13 - the VCO runs at reference times integer plus fraction times ratio, the output at VCO over the divider.
`timescale 1ns/100ps
module fllrs_ctrl
  import fllrs_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [1:0][3:0]       aif_sample_rate,
  input  wire logic [1:0][3:0]       aif_clock_ratio,
  input  wire logic [1:0][4:0]       aif_bclk_div,
  input  wire logic [1:0]            aif_adc_en,
  input  wire logic [1:0]            aif_dac_en,
  input  wire logic [1:0]            aif_adc_div_set,
  input  wire logic [1:0]            aif_dac_div_set,
  input  wire logic                  aif_same_source,
  input  wire logic                  aif_system_clock_sel,
  input  wire logic                  ref_tick,
  input  wire logic                  vco_tick,
  output logic                       loop_primary_enable,
  output logic                       loop_oscillator_enable,
  output logic                       loop_output_tick,
  output logic      [4:0]            vco_ratio,
  output logic      [REFDIV_W-1:0]   reference_divider,
  output logic      [MULT_W-1:0]     loop_eff_mult,
  output logic      [3:0]            rate_error_code,
  output logic                       irq
);

  // ---------------------------------------------------------------
  // rate checker
  // ---------------------------------------------------------------
  fllrs_rate_if rif ();

  assign rif.sample_rate = aif_sample_rate;
  assign rif.clk_ratio   = aif_clock_ratio;
  assign rif.bclk_div    = aif_bclk_div;
  assign rif.adc_en      = aif_adc_en;
  assign rif.dac_en      = aif_dac_en;
  assign rif.adc_div_set = aif_adc_div_set;
  assign rif.dac_div_set = aif_dac_div_set;
  assign rif.same_source = aif_same_source;
  assign rif.system_clock_aif  = aif_system_clock_sel;

  fllrs_rate_check u_check (
    .rif (rif.chk)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [1:0]            ctrl_q;
  logic [OUTDIV_W-1:0]   outdiv_q;
  logic [RATIO_W-1:0]    ratio_q;
  logic [FRAC_W-1:0]     theta_q;
  logic [INT_W-1:0]      nmul_q;
  logic [REFDIV_W-1:0]   refdiv_q;
  logic [FRAC_W-1:0]     lambda_q;
  logic                  fmode_q;
  logic [EV_W-1:0]       ist_q;
  logic [EV_W-1:0]       ien_q;
  logic [3:0]            rerr_q;
  logic                  wr_q;
  logic [11:0]           widx_q;
  logic [31:0]           hrdata_q;

  function automatic logic is_mapped(input logic [31:0] a);
    logic [11:0] idx;
    idx = a[13:2];
    return (a[31:14] == 18'h0) && (a[1:0] == 2'b00) &&
           (idx inside {IDX_RATE_STATUS, IDX_LOOP_CTRL, IDX_LOOP_DIV,
                        IDX_FRAC_NUM, IDX_INT_MULT, IDX_REF_DIV,
                        IDX_FRAC_DEN, IDX_FRAC_MODE, IDX_IRQ_STATUS,
                        IDX_IRQ_ENABLE, IDX_IRQ_CLEAR, IDX_EFF_MULT});
  endfunction

  // ---------------------------------------------------------------
  // ahb-lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  wire        take   = hsel & hready & htrans[1];
  wire        a_map  = is_mapped(haddr);
  wire [11:0] a_idx  = haddr[13:2];
  wire [15:0] wdat   = hwdata[15:0];

  wire wr_ctrl  = wr_q && (widx_q == IDX_LOOP_CTRL);
  wire wr_div   = wr_q && (widx_q == IDX_LOOP_DIV);
  wire wr_num   = wr_q && (widx_q == IDX_FRAC_NUM);
  wire wr_int   = wr_q && (widx_q == IDX_INT_MULT);
  wire wr_ref   = wr_q && (widx_q == IDX_REF_DIV);
  wire wr_den   = wr_q && (widx_q == IDX_FRAC_DEN);
  wire wr_fmode = wr_q && (widx_q == IDX_FRAC_MODE);
  wire wr_ien   = wr_q && (widx_q == IDX_IRQ_ENABLE);
  wire wr_iclr  = wr_q && (widx_q == IDX_IRQ_CLEAR);

  // write-only and unmapped words read as zero
  wire [15:0] rd_word =
    (a_idx == IDX_RATE_STATUS) ? {12'h000, rerr_q} :                // RL1
    (a_idx == IDX_LOOP_CTRL)   ? {14'h0000, ctrl_q} :
    (a_idx == IDX_LOOP_DIV)    ? {2'b00, outdiv_q, 5'h00, ratio_q} :
    (a_idx == IDX_FRAC_NUM)    ? theta_q :
    (a_idx == IDX_INT_MULT)    ? {1'b0, nmul_q, 5'h00} :
    (a_idx == IDX_REF_DIV)     ? {11'h000, refdiv_q, 3'h0} :
    (a_idx == IDX_FRAC_DEN)    ? lambda_q :
    (a_idx == IDX_FRAC_MODE)   ? (FMODE_RSVD | {15'h0000, fmode_q}) :
    (a_idx == IDX_IRQ_STATUS)  ? {12'h000, ist_q} :
    (a_idx == IDX_IRQ_ENABLE)  ? {12'h000, ien_q} :
    (a_idx == IDX_EFF_MULT)    ? {1'b0, loop_eff_mult} :
                                 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q     <= 1'b0;
      widx_q   <= 12'h000;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q     <= take & hwrite & a_map;
      widx_q   <= a_idx;
      hrdata_q <= (take & !hwrite & a_map) ? {16'h0000, rd_word}
                                           : 32'h0000_0000;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // loop configuration
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= RST_LOOP_CTRL;
      outdiv_q <= RST_OUTDIV;
      ratio_q  <= RST_RATIO;
      theta_q  <= RST_FRAC;
      nmul_q   <= RST_INT;
      refdiv_q <= RST_REFDIV;
      lambda_q <= RST_FRAC;
      fmode_q  <= 1'b0;
      ien_q    <= '0;
    end else begin
      if (wr_ctrl)  ctrl_q   <= wdat[OSC_EN_BIT:LOOP_EN_BIT];    // RL4
      if (wr_div)   outdiv_q <= wdat[OUTDIV_LSB+:OUTDIV_W];      // RL6
      if (wr_div)   ratio_q  <= wdat[RATIO_LSB+:RATIO_W];        // RL7
      if (wr_num)   theta_q  <= wdat;                            // RL8
      if (wr_int)   nmul_q   <= wdat[INT_LSB+:INT_W];            // RL9
      if (wr_ref)   refdiv_q <= wdat[REFDIV_LSB+:REFDIV_W];      // RL12
      if (wr_den)   lambda_q <= wdat;                            // RL10
      if (wr_fmode) fmode_q  <= wdat[FMODE_BIT];                 // RL11
      if (wr_ien)   ien_q    <= wdat[EV_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // active copy, taken when the loop starts
  // ---------------------------------------------------------------
  // the copy is only loaded at start, so software must write every
  // other field before the enable; later edits wait for a restart, except the reference divide, which drives its pins at once
  logic                  run_q;
  logic [OUTDIV_W-1:0]   a_outdiv_q;
  logic [RATIO_W-1:0]    a_ratio_q;
  logic [FRAC_W-1:0]     a_theta_q;
  logic [INT_W-1:0]      a_nmul_q;
  logic [FRAC_W-1:0]     a_lambda_q;
  logic                  a_fmode_q;

  wire run_d   = |ctrl_q;                                        // RL4
  wire start   = run_d & !run_q;                                 // RL5
  wire en_rise = wr_ctrl & wdat[LOOP_EN_BIT] & !ctrl_q[LOOP_EN_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q      <= 1'b0;
      a_outdiv_q <= RST_OUTDIV;
      a_ratio_q  <= RST_RATIO;
      a_theta_q  <= RST_FRAC;
      a_nmul_q   <= RST_INT;
      a_lambda_q <= RST_FRAC;
      a_fmode_q  <= 1'b0;
    end else begin
      run_q <= run_d;
      if (start) begin                                           // RL5
        a_outdiv_q <= outdiv_q;
        a_ratio_q  <= ratio_q;
        a_theta_q  <= theta_q;
        a_nmul_q   <= nmul_q;
        a_lambda_q <= lambda_q;
        a_fmode_q  <= fmode_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // multiplier: integer plus fractional carry, times vco ratio
  // ---------------------------------------------------------------
  function automatic logic [2:0] ratio_shift(input logic [2:0] r);
    return r[2] ? 3'h4 : {1'b0, r[1:0]};                         // RL7
  endfunction

  // decoded ratio is registered with the active copy so the pin is a flop
  logic [4:0] vratio_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      vratio_q <= 5'h01;
    else if (start)
      vratio_q <= 5'h01 << ratio_shift(ratio_q);                 // RL7
  end

  logic [FRAC_W-1:0] acc_q;
  logic [MULT_W-1:0] mult_q;

  // fraction ignored in integer mode or with a zero denominator
  wire               frac_on = a_fmode_q && (a_lambda_q != 16'h0000);
  wire [FRAC_W:0]    acc_sum = {1'b0, acc_q} + {1'b0, a_theta_q};
  wire               carry   = frac_on && (acc_sum >= {1'b0, a_lambda_q});
  wire [FRAC_W:0]    acc_nxt = carry ? acc_sum - {1'b0, a_lambda_q}
                                     : acc_sum;
  wire [INT_W:0]     per_mul = {1'b0, a_nmul_q} + {10'h000, carry};
  wire [MULT_W-1:0]  mult_d  = MULT_W'({4'h0, per_mul}
                                       << ratio_shift(a_ratio_q));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q  <= '0;
      mult_q <= '0;
    end else if (!run_d) begin
      acc_q  <= '0;
      mult_q <= '0;
    end else if (ref_tick & !start) begin
      acc_q  <= frac_on ? acc_nxt[FRAC_W-1:0] : '0;              // RL8
      mult_q <= mult_d;                                          // RL13
    end
  end

  // ---------------------------------------------------------------
  // output divider: one output tick per code+1 vco ticks
  // ---------------------------------------------------------------
  logic [OUTDIV_W-1:0] dcnt_q;
  logic                otick_q;

  wire div_ok = a_outdiv_q >= OUTDIV_MIN;                        // RL6
  wire wrap   = dcnt_q >= a_outdiv_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dcnt_q  <= '0;
      otick_q <= 1'b0;
    end else begin
      otick_q <= run_q & div_ok & vco_tick & wrap;               // RL13
      if (!run_q || start || !div_ok)
        dcnt_q <= '0;
      else if (vco_tick)
        dcnt_q <= wrap ? '0 : dcnt_q + 1'b1;                     // RL6
    end
  end

  // ---------------------------------------------------------------
  // events and interrupt; a new event beats a clear in one cycle
  // ---------------------------------------------------------------
  wire [3:0] rerr_d = rif.err_code;
  logic [EV_W-1:0] ev;
  logic            irq_q;

  always_comb begin
    ev                = '0;
    ev[EV_RATE_ERR]   = (rerr_d != RERR_NONE) && (rerr_d != rerr_q);
    ev[EV_OUTDIV_BAD] = start && (outdiv_q < OUTDIV_MIN);
    ev[EV_FRAC_MODE]  = en_rise && (theta_q != 16'h0000) && !fmode_q;
    ev[EV_LOOP_ON]    = en_rise;
  end

  wire [EV_W-1:0] clr = wr_iclr ? wdat[EV_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rerr_q <= RERR_NONE;
      ist_q  <= '0;
      irq_q  <= 1'b0;
    end else begin
      rerr_q <= rerr_d;                                          // RL1
      ist_q  <= (ist_q & ~clr) | ev;
      irq_q  <= |(((ist_q & ~clr) | ev) & ien_q);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign loop_primary_enable    = ctrl_q[LOOP_EN_BIT];
  assign loop_oscillator_enable = ctrl_q[OSC_EN_BIT];            // RL4
  assign loop_output_tick       = otick_q;
  assign vco_ratio              = vratio_q;
  assign reference_divider      = refdiv_q;
  assign loop_eff_mult          = mult_q;
  assign rate_error_code        = rerr_q;
  assign irq                    = irq_q;

endmodule

// [tb/fllrs_ctrl_sva.sv]
`timescale 1ns/100ps
module fllrs_ctrl_sva
  import fllrs_pkg::*;
(
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            hsel,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic            hready,
  input wire logic [31:0]     hrdata,
  input wire logic            hreadyout,
  input wire logic            hresp,
  input wire logic [1:0][3:0] aif_sample_rate,
  input wire logic [1:0][4:0] aif_bclk_div,
  input wire logic            vco_tick,
  input wire logic            loop_primary_enable,
  input wire logic            loop_output_tick,
  input wire logic [4:0]      vco_ratio,
  input wire logic [3:0]      rate_error_code
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_rate_bad;
    aif_sample_rate[0] > SR_MAX;
  endsequence
  // a bad rate outranks a bad divide, so both rates must be legal
  sequence s_div_bad;
    aif_sample_rate[0] <= SR_MAX && aif_sample_rate[1] <= SR_MAX &&
      aif_bclk_div[0] > BDIV_MAX;
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_bus_ready: assert property (hreadyout)
    else $error("slave stalled the bus");
  a_bus_okay: assert property (!hresp)
    else $error("slave gave an error response");
  a_rdata_idle: assert property ((hrdata != 32'h0) |->
    $past(hsel && hready && htrans[1] && !hwrite))
    else $error("read data outside a read data phase");
  a_rate_invalid: assert property (s_rate_bad |=>
    rate_error_code == RERR_SR) else $error("bad rate not flagged");
  a_divide_invalid: assert property (s_div_bad |=>
    rate_error_code == RERR_DIV) else $error("bad divide not flagged");
  a_ratio_onehot: assert property (loop_primary_enable |->
    $onehot(vco_ratio)) else $error("vco ratio not a power of two");
  a_tick_spacing: assert property (loop_output_tick |=>
    !loop_output_tick [*3]) else $error("output divide below four");
  a_tick_cause: assert property (
    loop_output_tick |-> $past(vco_tick))
    else $error("output tick without vco tick");
endmodule
bind fllrs_ctrl fllrs_ctrl_sva i_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .aif_sample_rate(aif_sample_rate), .aif_bclk_div(aif_bclk_div),
  .vco_tick(vco_tick), .loop_primary_enable(loop_primary_enable),
  .loop_output_tick(loop_output_tick), .vco_ratio(vco_ratio),
  .rate_error_code(rate_error_code));

// [tb/fll_and_rate_status_ctrl_bench.sv]
`timescale 1ns/100ps
module fll_and_rate_status_ctrl_bench;
  import fllrs_pkg::*;
  logic            hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]     haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]      htrans = 2'h0, ae, de, ads, dds, rdv;
  logic [1:0][3:0] sr, cr;
  logic [1:0][4:0] bd;
  logic            ss, sys, rt, vt, hready, hreadyout, hresp;
  logic            lpe, loe, lot, irq;
  logic [4:0]      vr;
  logic [14:0]     em;
  logic [3:0]      rec;
  int              failures = 0, n_compared = 0;
  assign hready = hreadyout;
  always #20 hclk = ~hclk;
  fllrs_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .aif_sample_rate(sr),
    .aif_clock_ratio(cr), .aif_bclk_div(bd), .aif_adc_en(ae),
    .aif_dac_en(de), .aif_adc_div_set(ads), .aif_dac_div_set(dds),
    .aif_same_source(ss), .aif_system_clock_sel(sys), .ref_tick(rt),
    .vco_tick(vt), .loop_primary_enable(lpe),
    .loop_oscillator_enable(loe), .loop_output_tick(lot),
    .vco_ratio(vr), .reference_divider(rdv), .loop_eff_mult(em),
    .rate_error_code(rec), .irq(irq));
  // ---------------------------------------------------------------
  // reporting and bus tasks
  // ---------------------------------------------------------------
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic rdy;
    int n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        failures++;
        end_sim;
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic [11:0] i, input logic w,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, i, 2'h0};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task wr(input logic [11:0] i, input logic [31:0] d);
    bus(i, 1'b1, d);
  endtask
  task rdc(input string nm, input logic [11:0] i, input logic [31:0] e);
    bus(i, 1'b0, 32'h0);
    chk(nm, rd, e);
  endtask
  // legal rates on both interfaces, no enables: no rate error
  task dflt;
    sr <= 8'h88; cr <= 8'h33; bd <= 10'h0; ae <= 2'h0; de <= 2'h0;
    ads <= 2'h0; dds <= 2'h0; ss <= 1'b0; sys <= 1'b0;
  endtask
  task automatic ticks(input int n, input logic [31:0] e);
    int c = 0;
    repeat (n) begin
      @(posedge hclk);
      c += lot;
    end
    chk("output ticks", c, e);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    dflt;
    rt <= 1'b1;
    vt <= 1'b1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("rate status", IDX_RATE_STATUS, 32'h0);
    rdc("loop ctrl", IDX_LOOP_CTRL, 32'h0);
    rdc("divider", IDX_LOOP_DIV, 32'h0);
    rdc("frac mode", IDX_FRAC_MODE, 32'h6);
    wr(IDX_FRAC_NUM, 32'hffff);
    rdc("numerator", IDX_FRAC_NUM, 32'hffff);
    wr(IDX_INT_MULT, 32'hffff);
    rdc("multiplier", IDX_INT_MULT, 32'h7fe0);
    wr(IDX_FRAC_DEN, 32'h1234);
    rdc("denominator", IDX_FRAC_DEN, 32'h1234);
    wr(IDX_REF_DIV, 32'h18);
    rdc("ref div", IDX_REF_DIV, 32'h18);
    chk("ref div out", rdv, 32'h3);
    wr(IDX_RATE_STATUS, 32'hf);
    rdc("status ro", IDX_RATE_STATUS, 32'h0);
    rdc("unmapped", 12'h300, 32'h0);
    // every rate error code in turn, interrupt still masked
    for (int k = 1; k < 10; k++) begin
      dflt;
      repeat (3) @(posedge hclk);
      chk("no rate error", rec, 32'h0);
      case (k)
        1: sr[0] <= 4'hb;
        2: bd[0] <= 5'h14;
        3: begin ads[0] <= 1'b1; dds[0] <= 1'b1; end
        4: cr[0] <= 4'h8;
        5: begin sr[0] <= 4'h9; ae[0] <= 1'b1; end
        6: cr[1] <= 4'h0;
        7: begin ae[0] <= 1'b1; de[0] <= 1'b1; end
        8: begin ss <= 1'b1; sr[1] <= 4'h7; end
        default: begin ss <= 1'b1; ae[1] <= 1'b1; de[1] <= 1'b1; end
      endcase
      repeat (3) @(posedge hclk);
      chk("rate code", rec, k);
      chk("irq masked", irq, 32'h0);
      rdc("rate status", IDX_RATE_STATUS, k);
    end
    dflt;
    rdc("irq status", IDX_IRQ_STATUS, 32'h1);
    wr(IDX_IRQ_ENABLE, 32'h1);
    repeat (3) @(posedge hclk);
    chk("irq raised", irq, 32'h1);
    wr(IDX_IRQ_CLEAR, 32'h1);
    repeat (3) @(posedge hclk);
    chk("irq cleared", irq, 32'h0);
    wr(IDX_INT_MULT, 32'h00a0);
    wr(IDX_LOOP_DIV, 32'h0302);
    wr(IDX_LOOP_CTRL, 32'h1);
    repeat (4) @(posedge hclk);
    chk("loop enable", lpe, 32'h1);
    chk("vco ratio", vr, 32'h4);
    chk("eff mult", em, 32'h14);
    ticks(40, 32'ha);
    wr(IDX_LOOP_CTRL, 32'h0);
    wr(IDX_LOOP_DIV, 32'h0506);
    wr(IDX_LOOP_CTRL, 32'h3);
    repeat (4) @(posedge hclk);
    chk("osc enable", loe, 32'h1);
    chk("vco ratio", vr, 32'h10);
    chk("eff mult", em, 32'h50);
    ticks(60, 32'ha);
    wr(IDX_LOOP_CTRL, 32'h0);
    wr(IDX_LOOP_DIV, 32'h0200);
    wr(IDX_LOOP_CTRL, 32'h1);
    ticks(40, 32'h0);
    rdc("irq status", IDX_IRQ_STATUS, 32'he);
    // half fraction: the multiplier alternates between n and n+1
    wr(IDX_LOOP_CTRL, 32'h0);
    wr(IDX_FRAC_NUM, 32'h091a);
    wr(IDX_FRAC_MODE, 32'h1);
    wr(IDX_LOOP_CTRL, 32'h1);
    repeat (4) @(posedge hclk);
    rd = em;
    @(posedge hclk);
    chk("frac mult", rd + em, 32'hb);
    end_sim;
  end
endmodule
